/* File: kbhp_pkg.sv */
// constants for the keyboard-controller host port
// Overview of operation
// - data port write: latch, clear C/D, set full
// - command port write: latch, set C/D, set full
// - data port read returns output; flags mode clears
// - command port read returns status, no side effects
// - core buffer write loads output, sets output-full
// - status bit 3 follows address line two
// - flags mode, irq bit one: kbd irq=output-full
// - flags mode, irq bit zero: kbd irq low
// - no flags mode: kbd irq follows port bit
// - flags mode, aux bit one: aux=not input-full
// - no flags mode: aux irq follows port bit
// - gate A20 driven from its port bit
// - push-pull pins: low, or brief active pull-up
// - open-drain pins: low or released, no pull-up
// - special pins never inputs or inverted
// - kbd clock/data driven inverted, read back
// - mouse clock/data driven inverted, read back
// - core input read clears input-full and interrupt
// - status cleared on reset, core writes user bits
package kbhp_pkg;
  localparam logic [15:0] ADDR_DATA     = 16'h0060;
  localparam logic [15:0] ADDR_CMD      = 16'h0064;
  localparam int          ADDR_CD_BIT   = 2;
  // status byte layout
  localparam int          ST_OBF        = 0;
  localparam int          ST_IBF        = 1;
  localparam int          ST_CD         = 3;
  localparam logic [7:0]  ST_USER_MASK  = 8'hF4;
  localparam logic [7:0]  ST_RESET      = 8'h00;
  // port 2 bit positions
  localparam int          P2_GATE_A20   = 1;
  localparam int          P2_MOUSE_DAT  = 2;
  localparam int          P2_MOUSE_CLK  = 3;
  localparam int          P2_KBD_IRQ    = 4;
  localparam int          P2_AUX_IRQ    = 5;
  localparam int          P2_KBD_CLK    = 6;
  localparam int          P2_KBD_DAT    = 7;
  // pins low and both irqs low out of reset
  localparam logic [7:0]  P2_RESET      = 8'hCC;
  // special pins a, b, c sit on port 1 bits 7, 6, 2
  localparam int          P1_SPC_A      = 7;
  localparam int          P1_SPC_B      = 6;
  localparam int          P1_SPC_C      = 2;
  localparam logic [7:0]  P1_RESET      = 8'hFF;
  localparam int          SPC_NUM       = 3;
  // active pull-up time, 125 controller clocks
  localparam int          CLK_MHZ       = 250;
  localparam int          PULLUP_NS     = 500;
  localparam int          PULLUP_CYC    = (PULLUP_NS * CLK_MHZ) / 1000;
  localparam int          PU_W          = 8;
  localparam logic [7:0]  PU_LOAD       = PU_W'(PULLUP_CYC);
  localparam logic [7:0]  PU_ZERO       = 8'h00;
  localparam logic [7:0]  PU_ONE        = 8'h01;
  // output fifo between core and output register
  localparam int          FIFO_W        = 8;
  localparam int          FIFO_D        = 4;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
endpackage

/* File: kbhp_top.sv */
// host mailbox, irq gating and port pins of the keyboard controller
`timescale 1ns/10ps
`default_nettype none

module kbhp_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  // fill side
  input  wire logic         in_valid,
  output var  logic         in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output var  logic         out_valid,
  input  wire logic         out_ready,
  output var  logic [W-1:0] out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic          push;
  logic          pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(D - 1)) ? '0 : p + AW'(1);
  endfunction

  assign in_ready  = (count != CNT_MAX);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= ptr_inc(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= ptr_inc(rd_ptr);
      end
      if (push && !pop) begin
        count <= count + CW'(1);
      end else if (pop && !push) begin
        count <= count - CW'(1);
      end
    end
  end
endmodule

module kbhp_top (
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  // host i/o cycles
  input  wire logic [15:0] HOST_ADDR_I,
  input  wire logic        HOST_WR_I,
  input  wire logic        HOST_RD_I,
  input  wire logic [7:0]  HOST_WDATA_I,
  output var  logic [7:0]  HOST_RDATA_O,
  output var  logic        HOST_RVALID_O,
  // core side of the mailbox
  input  wire logic        CPU_BUF_WR_I,
  input  wire logic [7:0]  CPU_BUF_WDATA_I,
  output var  logic        CPU_BUF_RDY_O,
  input  wire logic        CPU_BUF_RD_I,
  output var  logic [7:0]  CPU_BUF_RDATA_O,
  output var  logic        CPU_IBF_IRQ_O,
  input  wire logic        CPU_OBF_CLR_I,
  input  wire logic        CPU_STAT_WR_I,
  input  wire logic [7:0]  CPU_STAT_WDATA_I,
  output var  logic [7:0]  CPU_STAT_O,
  input  wire logic        CPU_EN_FLAGS_I,
  // core ports
  input  wire logic        CPU_P1_WR_I,
  input  wire logic [7:0]  CPU_P1_WDATA_I,
  input  wire logic        CPU_P2_WR_I,
  input  wire logic [7:0]  CPU_P2_WDATA_I,
  input  wire logic        CPU_SPC_OD_I,
  output var  logic [1:0]  CPU_TEST_O,
  output var  logic [1:0]  CPU_P1_IN_O,
  // system outputs
  output var  logic        KBD_IRQ_O,
  output var  logic        AUX_IRQ_O,
  output var  logic        GATE_A20_O,
  // special port pins c, b, a on bits 0, 1, 2
  output var  logic [2:0]  SPC_PIN_O,
  output var  logic [2:0]  SPC_PIN_OE_O,
  // open-drain keyboard and mouse pins
  input  wire logic        KBD_CLK_I,
  output var  logic        KBD_CLK_OE_O,
  input  wire logic        KBD_DAT_I,
  output var  logic        KBD_DAT_OE_O,
  input  wire logic        MOUSE_CLK_I,
  output var  logic        MOUSE_CLK_OE_O,
  input  wire logic        MOUSE_DAT_I,
  output var  logic        MOUSE_DAT_OE_O
);
  logic [7:0] input_reg;
  logic [7:0] output_reg;
  logic [7:0] status;
  logic [7:0] port1;
  logic [7:0] port2;
  logic       en_flags;
  logic [2:0] spc_val;
  logic [2:0] spc_prev;
  logic [7:0] pu_cnt [3];

  logic       fifo_valid;
  logic       fifo_ready;
  logic [7:0] fifo_data;
  logic       host_data_wr;
  logic       host_cmd_wr;
  logic       host_data_rd;
  logic       host_cmd_rd;
  logic       obf_load;
  logic       obf_clr;
  logic       next_kbd_irq;
  logic       next_aux_irq;

  function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] port);
    addr_hit = (a == port);
  endfunction

  assign host_data_wr = HOST_WR_I && addr_hit(HOST_ADDR_I, kbhp_pkg::ADDR_DATA);
  assign host_cmd_wr  = HOST_WR_I && addr_hit(HOST_ADDR_I, kbhp_pkg::ADDR_CMD);
  assign host_data_rd = HOST_RD_I && addr_hit(HOST_ADDR_I, kbhp_pkg::ADDR_DATA);
  assign host_cmd_rd  = HOST_RD_I && addr_hit(HOST_ADDR_I, kbhp_pkg::ADDR_CMD);

  // core writes queue here; the output register drains one only while it is empty
  kbhp_fifo #(
    .W(kbhp_pkg::FIFO_W),
    .D(kbhp_pkg::FIFO_D)
  ) u_out_fifo (
    .clk      (CLK_I),
    .rst      (RST_I),
    .in_valid (CPU_BUF_WR_I),
    .in_ready (fifo_ready),
    .in_data  (CPU_BUF_WDATA_I),
    .out_valid(fifo_valid),
    .out_ready(!status[kbhp_pkg::ST_OBF]),
    .out_data (fifo_data)
  );

  assign obf_load = fifo_valid && !status[kbhp_pkg::ST_OBF];
  // without flags mode the host read leaves output-full for firmware to clear
  assign obf_clr  = (host_data_rd && en_flags) || CPU_OBF_CLR_I;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      CPU_BUF_RDY_O <= 1'b0;
    end else begin
      CPU_BUF_RDY_O <= fifo_ready && !(CPU_BUF_WR_I && CPU_BUF_RDY_O);
    end
  end

  // host to core byte; a command write and a data write differ only in C/D
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      input_reg <= kbhp_pkg::BYTE_ZERO;
    end else if (host_data_wr || host_cmd_wr) begin
      input_reg <= HOST_WDATA_I;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      output_reg <= kbhp_pkg::BYTE_ZERO;
    end else if (obf_load) begin
      output_reg <= fifo_data;
    end
  end

  // status byte: hardware sets win over clears in the same cycle
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      status <= kbhp_pkg::ST_RESET;
    end else begin
      if (CPU_STAT_WR_I) begin
        status <= (status & ~kbhp_pkg::ST_USER_MASK)
                | (CPU_STAT_WDATA_I & kbhp_pkg::ST_USER_MASK);
      end
      if (host_data_wr || host_cmd_wr) begin
        status[kbhp_pkg::ST_CD]  <= HOST_ADDR_I[kbhp_pkg::ADDR_CD_BIT];
        status[kbhp_pkg::ST_IBF] <= 1'b1;
      end else if (CPU_BUF_RD_I) begin
        status[kbhp_pkg::ST_IBF] <= 1'b0;
      end
      if (obf_load) begin
        status[kbhp_pkg::ST_OBF] <= 1'b1;
      end else if (obf_clr) begin
        status[kbhp_pkg::ST_OBF] <= 1'b0;
      end
    end
  end

  // host read answer one cycle after the strobe; status read touches nothing
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      HOST_RDATA_O  <= kbhp_pkg::BYTE_ZERO;
      HOST_RVALID_O <= 1'b0;
    end else begin
      HOST_RVALID_O <= host_data_rd || host_cmd_rd;
      if (host_data_rd) begin
        HOST_RDATA_O <= output_reg;
      end else if (host_cmd_rd) begin
        HOST_RDATA_O <= status;
      end
    end
  end

  // core view of the mailbox
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      CPU_BUF_RDATA_O <= kbhp_pkg::BYTE_ZERO;
      CPU_STAT_O      <= kbhp_pkg::ST_RESET;
      CPU_IBF_IRQ_O   <= 1'b0;
    end else begin
      CPU_BUF_RDATA_O <= input_reg;
      CPU_STAT_O      <= status;
      CPU_IBF_IRQ_O   <= status[kbhp_pkg::ST_IBF] && !CPU_BUF_RD_I;
    end
  end

  // flags mode stays on once entered, until reset
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      en_flags <= 1'b0;
    end else if (CPU_EN_FLAGS_I) begin
      en_flags <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      port1 <= kbhp_pkg::P1_RESET;
      port2 <= kbhp_pkg::P2_RESET;
    end else begin
      if (CPU_P1_WR_I) begin
        port1 <= CPU_P1_WDATA_I;
      end
      if (CPU_P2_WR_I) begin
        port2 <= CPU_P2_WDATA_I;
      end
    end
  end

  // interrupt gating
  always_comb begin
    if (en_flags) begin
      next_kbd_irq = port2[kbhp_pkg::P2_KBD_IRQ]
                   && status[kbhp_pkg::ST_OBF];
      next_aux_irq = port2[kbhp_pkg::P2_AUX_IRQ]
                   && !status[kbhp_pkg::ST_IBF];
    end else begin
      next_kbd_irq = port2[kbhp_pkg::P2_KBD_IRQ];
      next_aux_irq = port2[kbhp_pkg::P2_AUX_IRQ];
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      KBD_IRQ_O  <= 1'b0;
      AUX_IRQ_O  <= 1'b0;
      GATE_A20_O <= 1'b0;
    end else begin
      KBD_IRQ_O  <= next_kbd_irq;
      AUX_IRQ_O  <= next_aux_irq;
      GATE_A20_O <= port2[kbhp_pkg::P2_GATE_A20];
    end
  end

  // special pins take the port value straight, with no input or invert path
  assign spc_val = {port1[kbhp_pkg::P1_SPC_A],
                    port1[kbhp_pkg::P1_SPC_B],
                    port1[kbhp_pkg::P1_SPC_C]};

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      spc_prev <= 3'h7;
    end else begin
      spc_prev <= spc_val;
    end
  end

  // a rising port value arms the active pull-up for a fixed time
  for (genvar i = 0; i < kbhp_pkg::SPC_NUM; i++) begin : g_spc
    always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
        pu_cnt[i] <= kbhp_pkg::PU_ZERO;
      end else if (!spc_val[i] || CPU_SPC_OD_I) begin
        pu_cnt[i] <= kbhp_pkg::PU_ZERO;
      end else if (!spc_prev[i]) begin
        pu_cnt[i] <= kbhp_pkg::PU_LOAD;
      end else if (pu_cnt[i] != kbhp_pkg::PU_ZERO) begin
        pu_cnt[i] <= pu_cnt[i] - kbhp_pkg::PU_ONE;
      end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
        SPC_PIN_O[i]    <= 1'b0;
        SPC_PIN_OE_O[i] <= 1'b0;
      end else begin
        SPC_PIN_O[i]    <= spc_val[i] && !CPU_SPC_OD_I;
        SPC_PIN_OE_O[i] <= !spc_val[i]
                         || (!CPU_SPC_OD_I && !spc_prev[i])
                         || (!CPU_SPC_OD_I && pu_cnt[i] > kbhp_pkg::PU_ONE);
      end
    end
  end

  // open-drain pins: a port bit of one pulls the pin low
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      KBD_CLK_OE_O   <= 1'b1;
      KBD_DAT_OE_O   <= 1'b1;
      MOUSE_CLK_OE_O <= 1'b1;
      MOUSE_DAT_OE_O <= 1'b1;
      CPU_TEST_O     <= 2'h0;
      CPU_P1_IN_O    <= 2'h0;
    end else begin
      KBD_CLK_OE_O   <= port2[kbhp_pkg::P2_KBD_CLK];
      KBD_DAT_OE_O   <= port2[kbhp_pkg::P2_KBD_DAT];
      MOUSE_CLK_OE_O <= port2[kbhp_pkg::P2_MOUSE_CLK];
      MOUSE_DAT_OE_O <= port2[kbhp_pkg::P2_MOUSE_DAT];
      CPU_TEST_O     <= {MOUSE_CLK_I, KBD_CLK_I};
      CPU_P1_IN_O    <= {MOUSE_DAT_I, KBD_DAT_I};
    end
  end
endmodule

`default_nettype wire

/* File: kbhp_sva.sv */
// assertions on the keyboard-controller host port
`timescale 1ns/10ps
`default_nettype none
module kbhp_sva (
  // clock and reset
  input wire logic        CLK_I,
  input wire logic        RST_I,
  // strobes in
  input wire logic [15:0] HOST_ADDR_I,
  input wire logic        HOST_WR_I,
  input wire logic        HOST_RD_I,
  input wire logic        CPU_BUF_RD_I,
  input wire logic        CPU_P1_WR_I,
  input wire logic [7:0]  CPU_P1_WDATA_I,
  input wire logic        CPU_P2_WR_I,
  input wire logic [7:0]  CPU_P2_WDATA_I,
  // outputs watched
  input wire logic        HOST_RVALID_O,
  input wire logic        CPU_IBF_IRQ_O,
  input wire logic [7:0]  CPU_STAT_O,
  input wire logic        KBD_IRQ_O,
  input wire logic        GATE_A20_O,
  input wire logic [2:0]  SPC_PIN_O,
  input wire logic [2:0]  SPC_PIN_OE_O,
  input wire logic        KBD_CLK_OE_O,
  input wire logic        KBD_DAT_OE_O,
  input wire logic        MOUSE_CLK_OE_O,
  input wire logic        MOUSE_DAT_OE_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);
  logic hit_d;
  logic hit_c;
  assign hit_d = HOST_ADDR_I == kbhp_pkg::ADDR_DATA;
  assign hit_c = HOST_ADDR_I == kbhp_pkg::ADDR_CMD;
  // lone strobes, so that no later write masks the result
  sequence p2_lone_s;
    CPU_P2_WR_I ##1 !CPU_P2_WR_I;
  endsequence
  sequence p1_lone_s;
    CPU_P1_WR_I ##1 !CPU_P1_WR_I;
  endsequence
  sequence wr_lone_s;
    HOST_WR_I ##1 !HOST_WR_I && !CPU_BUF_RD_I;
  endsequence
  rd_answer_a: assert property (
    HOST_RD_I && (hit_d || hit_c) |=> HOST_RVALID_O)
    else $error("read not answered");
  rd_ignore_a: assert property (
    HOST_RD_I && !hit_d && !hit_c |=> !HOST_RVALID_O)
    else $error("unmapped read answered");
  cmd_flag_a: assert property (
    hit_c ##0 wr_lone_s |=> CPU_STAT_O[3] && CPU_STAT_O[1])
    else $error("command write flags wrong");
  data_flag_a: assert property (
    hit_d ##0 wr_lone_s |=> !CPU_STAT_O[3] && CPU_STAT_O[1])
    else $error("data write flags wrong");
  ibf_clear_a: assert property (
    CPU_BUF_RD_I && !HOST_WR_I |-> ##2 !CPU_IBF_IRQ_O)
    else $error("input-full irq not withdrawn");
  kbd_mask_a: assert property (
    !CPU_P2_WDATA_I[4] ##0 p2_lone_s |=> !KBD_IRQ_O)
    else $error("kbd irq not forced low");
  gate_a20_a: assert property (
    p2_lone_s |=> GATE_A20_O == $past(CPU_P2_WDATA_I[1], 2))
    else $error("gate a20 wrong");
  kbd_pins_a: assert property (
    p2_lone_s |=> {KBD_CLK_OE_O, KBD_DAT_OE_O}
                  == $past({CPU_P2_WDATA_I[6], CPU_P2_WDATA_I[7]}, 2))
    else $error("kbd pin drive wrong");
  mouse_pins_a: assert property (
    p2_lone_s |=> {MOUSE_CLK_OE_O, MOUSE_DAT_OE_O} == $past(CPU_P2_WDATA_I[3:2], 2))
    else $error("mouse pin drive wrong");
  spc_low_a: assert property (
    !CPU_P1_WDATA_I[7] ##0 p1_lone_s |=> SPC_PIN_OE_O[2] && !SPC_PIN_O[2])
    else $error("special pin not driven low");
  irq_reset_a: assert property ($fell(RST_I) |-> !KBD_IRQ_O)
    else $error("kbd irq high after reset");
endmodule
bind kbhp_top kbhp_sva u_sva (.CLK_I, .RST_I, .HOST_ADDR_I, .HOST_WR_I, .HOST_RD_I,
  .CPU_BUF_RD_I, .CPU_P1_WR_I, .CPU_P1_WDATA_I, .CPU_P2_WR_I, .CPU_P2_WDATA_I,
  .HOST_RVALID_O, .CPU_IBF_IRQ_O, .CPU_STAT_O, .KBD_IRQ_O, .GATE_A20_O, .SPC_PIN_O,
  .SPC_PIN_OE_O, .KBD_CLK_OE_O, .KBD_DAT_OE_O, .MOUSE_CLK_OE_O, .MOUSE_DAT_OE_O);
`default_nettype wire

/* File: kbhp_host_model.sv */
// host processor model issuing i/o cycles
`timescale 1ns/10ps
`default_nettype none
module kbhp_host_model (
  // clock
  input  wire logic        clk_i,
  // i/o cycle
  output var  logic [15:0] addr_o,
  output var  logic        wr_o,
  output var  logic        rd_o,
  output var  logic [7:0]  wdata_o,
  input  wire logic [7:0]  rdata_i,
  input  wire logic        rvalid_i
);
  initial begin
    addr_o = 16'h00FF;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    // released data lines show junk, not the last byte
    wdata_o = ~d;
  endtask
  // answer stands just after the edge that takes the strobe
  task automatic io_rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    d = rdata_i;
    ok = rvalid_i;
  endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the keyboard-controller host port
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clk, rst, wr, rd, rvalid, ok, bwr, rdy, brd, ibf_irq, obf_clr, swr, en_fl;
  logic        p1wr, p2wr, od, kbd_irq_out, airq, a20, kc_oe, kd_oe, mc_oe, md_oe;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, bwdata, bdata, swdata, stat, p1d, p2d, v;
  logic [1:0]  test_in, p1_in;
  logic [2:0]  spc, spc_oe;
  logic [7:0]  pv [0:2] = '{8'h30, 8'hCE, 8'h95};
  int          num_errors = 0;
  int          samples_checked = 0;
  kbhp_top uut (.CLK_I(clk), .RST_I(rst), .HOST_ADDR_I(addr), .HOST_WR_I(wr), .HOST_RD_I(rd),
    .HOST_WDATA_I(wdata), .HOST_RDATA_O(rdata), .HOST_RVALID_O(rvalid), .CPU_BUF_WR_I(bwr),
    .CPU_BUF_WDATA_I(bwdata), .CPU_BUF_RDY_O(rdy), .CPU_BUF_RD_I(brd), .CPU_BUF_RDATA_O(bdata),
    .CPU_IBF_IRQ_O(ibf_irq), .CPU_OBF_CLR_I(obf_clr), .CPU_STAT_WR_I(swr),
    .CPU_STAT_WDATA_I(swdata), .CPU_STAT_O(stat), .CPU_EN_FLAGS_I(en_fl), .CPU_P1_WR_I(p1wr),
    .CPU_P1_WDATA_I(p1d), .CPU_P2_WR_I(p2wr), .CPU_P2_WDATA_I(p2d), .CPU_SPC_OD_I(od),
    .CPU_TEST_O(test_in), .CPU_P1_IN_O(p1_in), .KBD_IRQ_O(kbd_irq_out), .AUX_IRQ_O(airq),
    .GATE_A20_O(a20), .SPC_PIN_O(spc), .SPC_PIN_OE_O(spc_oe), .KBD_CLK_I(!kc_oe),
    .KBD_CLK_OE_O(kc_oe), .KBD_DAT_I(!kd_oe), .KBD_DAT_OE_O(kd_oe), .MOUSE_CLK_I(!mc_oe),
    .MOUSE_CLK_OE_O(mc_oe), .MOUSE_DAT_I(!md_oe), .MOUSE_DAT_OE_O(md_oe));
  kbhp_host_model host (.clk_i(clk), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata),
    .rdata_i(rdata), .rvalid_i(rvalid));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic st(input logic [7:0] exp);
    host.io_rd(kbhp_pkg::ADDR_CMD, v, ok);
    chk(v, exp);
    chk({7'h00, ok}, 8'h01);
  endtask
  task automatic p1(input logic [7:0] d);
    p1d = d;
    p1wr = 1'b1;
    cyc(1);
    p1wr = 1'b0;
    cyc(2);
  endtask
  task automatic p2(input logic [7:0] d);
    p2d = d;
    p2wr = 1'b1;
    cyc(1);
    p2wr = 1'b0;
    cyc(3);
  endtask
  task automatic push(input logic [7:0] d);
    int j;
    for (j = 0; j < 30 && rdy !== 1'b1; j++) cyc(1);
    if (j == 30) begin
      num_errors++;
      report_and_stop();
    end
    bwdata = d;
    bwr = 1'b1;
    cyc(1);
    bwr = 1'b0;
    cyc(1);
  endtask
  // host polls output-full before each data read
  task automatic pop(input logic [7:0] exp);
    int j;
    for (j = 0; j < 30; j++) begin
      host.io_rd(kbhp_pkg::ADDR_CMD, v, ok);
      if (v[kbhp_pkg::ST_OBF] === 1'b1) break;
    end
    if (j == 30) begin
      num_errors++;
      report_and_stop();
    end
    host.io_rd(kbhp_pkg::ADDR_DATA, v, ok);
    chk(v, exp);
  endtask
  initial begin
    cyc(20000);
    num_errors++;
    report_and_stop();
  end
  initial begin
    {rst, bwr, brd, obf_clr, swr, en_fl, p1wr, p2wr, od} = 9'h100;
    {bwdata, swdata, p1d, p2d} = 32'h0000_0000;
    cyc(5);
    rst = 1'b0;
    cyc(2);
    st(8'h00);
    chk({7'h00, kbd_irq_out}, 8'h00);
    foreach (pv[i]) begin
      p2(pv[i]);
      v = pv[i];
      chk({5'h00, kbd_irq_out, airq, a20}, {5'h00, v[4], v[5], v[1]});
      chk({4'h0, kc_oe, kd_oe, mc_oe, md_oe}, {4'h0, v[6], v[7], v[3:2]});
      chk({4'h0, test_in, p1_in}, {4'h0, ~v[3], ~v[6], ~v[2], ~v[7]});
    end
    host.io_wr(kbhp_pkg::ADDR_CMD, 8'hA5);
    cyc(2);
    chk({ibf_irq, bdata[6:0]}, 8'hA5);
    st(8'h0A);
    chk(stat, 8'h0A);
    chk(bdata, 8'hA5);
    brd = 1'b1;
    cyc(1);
    brd = 1'b0;
    st(8'h08);
    chk({7'h00, ibf_irq}, 8'h00);
    host.io_wr(kbhp_pkg::ADDR_DATA, 8'h3C);
    st(8'h02);
    host.io_wr(16'h0065, 8'hFF);
    host.io_rd(16'h0061, v, ok);
    chk({7'h00, ok}, 8'h00);
    swdata = 8'hFF;
    swr = 1'b1;
    cyc(1);
    swr = 1'b0;
    st(8'hF6);
    chk(stat, 8'hF6);
    swdata = 8'h00;
    swr = 1'b1;
    brd = 1'b1;
    cyc(1);
    {swr, brd} = 2'b00;
    push(8'h5A);
    pop(8'h5A);
    st(8'h01);
    obf_clr = 1'b1;
    cyc(1);
    obf_clr = 1'b0;
    st(8'h00);
    en_fl = 1'b1;
    cyc(1);
    en_fl = 1'b0;
    p2(8'h30);
    for (int i = 0; i < 5; i++) push(8'h10 + 8'(i));
    cyc(3);
    chk({5'h00, rdy, kbd_irq_out, airq}, 8'h03);
    for (int i = 0; i < 5; i++) pop(8'h10 + 8'(i));
    cyc(3);
    chk({6'h00, rdy, kbd_irq_out}, 8'h02);
    host.io_wr(kbhp_pkg::ADDR_DATA, 8'h77);
    cyc(3);
    chk({7'h00, airq}, 8'h00);
    p2(8'h20);
    push(8'h66);
    cyc(3);
    chk({7'h00, kbd_irq_out}, 8'h00);
    pop(8'h66);
    p1(8'h00);
    chk({2'b00, spc_oe, spc}, 8'h38);
    p1(8'h80);
    chk({2'b00, spc_oe, spc}, 8'h3C);
    cyc(100);
    chk({5'h00, spc_oe}, 8'h07);
    cyc(30);
    chk({5'h00, spc_oe}, 8'h03);
    od = 1'b1;
    p1(8'h00);
    p1(8'h84);
    chk({2'b00, spc_oe, spc}, 8'h10);
    report_and_stop();
  end
endmodule
`default_nettype wire
